// ==== design/sffl_top.v ====
// Purpose: fault flag raise/mask/filter/clear logic of a magnetic position sensor
// Assumes: all inputs synchronous to clk; update_tick pulses once per angle update
// Notes:   flags other than SPE, EUE and OSC clear on an error register read or on report_done, once the cause is gone
`timescale 1ns/1ps
`include "sffl_consts.vh"

module sffl_top #(
  parameter SAMPLE_W = 16
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [7:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  input  wire                update_tick,
  input  wire                linearizer_overflow,
  input  wire                frontend_overflow,
  input  wire                factory_trim_overflow,
  input  wire                customer_trim_overflow,
  input  wire [15:0]         pre_gain_angle,
  input  wire                gain_overflow,
  input  wire                post_offset_overflow,
  input  wire                osc_deviation_over,
  input  wire                selfcheck_mismatch,
  input  wire                angle_watchdog_miss,
  input  wire [SAMPLE_W-1:0] first_axis_sample,
  input  wire [SAMPLE_W-1:0] second_axis_sample,
  input  wire                eeprom_read_active,
  input  wire                ecc_single_err,
  input  wire                ecc_multi_err,
  input  wire                shadow_parity_bad,
  input  wire                undervoltage_trip,
  input  wire                report_done,
  input  wire                output_is_digital,
  output wire                gain_clip_on,
  output wire                post_offset_clip_on,
  output wire                uvd_threshold_high,
  output wire                output_error_state,
  output wire                first_frame_por,
  output wire                squared_radius_valid,
  output wire [8:0]          error_flags
);

  localparam QW = SAMPLE_W - 7;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg  [31:0]     ctrl_r;
  reg  [31:0]     limit_r;
  reg  [31:0]     bounds_r;
  reg  [8:0]      flag_r;
  reg  [8:0]      flag_nxt;
  reg  [2*QW:0]   radius_r;
  reg  [3:0]      period_r;
  reg             first_upd_r;
  reg             first_out_r;
  reg  [4:0]      ovf_cnt_r;
  reg  [4:0]      rad_cnt_r;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire err_rd  = bus_req & ~wb_we_i & (wb_adr_i == `SFFL_ADR_ERR);
  wire clr_ev  = err_rd | report_done;
  wire periodic = update_tick & (period_r == `SFFL_PERIODIC_UPD - 4'h1);

  wire ovf_mask   = ctrl_r[`SFFL_C_OVF_MASK];
  wire lin_mask   = ctrl_r[`SFFL_C_LIN_MASK];
  wire cor_mask   = ctrl_r[`SFFL_C_COR_MASK];
  wire lim_on     = ctrl_r[`SFFL_C_LIM_ON];
  wire [4:0] filt_cfg = ctrl_r[`SFFL_C_FILT_LSB+4:`SFFL_C_FILT_LSB];

  assign gain_clip_on        = ctrl_r[`SFFL_C_GAIN_ON];
  assign post_offset_clip_on = ctrl_r[`SFFL_C_POFF_ON];
  assign uvd_threshold_high  = ctrl_r[`SFFL_C_UVD_SEL];

  // ------------------------------------------------------------------
  // raw conditions
  // ------------------------------------------------------------------
  wire [15:0] lim_lo = limit_r[15:0];
  wire [15:0] lim_hi = limit_r[31:16];
  wire lim_out = lim_on & ((pre_gain_angle < lim_lo) | (pre_gain_angle > lim_hi));
  wire cor_raw = factory_trim_overflow | customer_trim_overflow | lim_out |
                 (gain_clip_on & gain_overflow) |
                 (post_offset_clip_on & post_offset_overflow);
  wire ovf_raw = (linearizer_overflow & ~lin_mask) | frontend_overflow |
                 (cor_raw & ~cor_mask);

  // floor by 128 is a plain shift of the unsigned sample
  wire [QW-1:0]   qa = first_axis_sample[SAMPLE_W-1:7];
  wire [QW-1:0]   qb = second_axis_sample[SAMPLE_W-1:7];
  // squares kept full width; a product inside a concatenation would be cut to operand width
  wire [2*QW-1:0] qa_sq = qa * qa;
  wire [2*QW-1:0] qb_sq = qb * qb;
  wire [2*QW:0]   rad_now = {1'b0, qa_sq} + {1'b0, qb_sq};
  wire [15:0]     r_lo = bounds_r[15:0];
  wire [15:0]     r_hi = bounds_r[31:16];
  wire [31:0]     lo_prod = r_lo * r_lo;
  wire [31:0]     hi_prod = r_hi * r_hi;
  wire [32:0]     lo_sq = {1'b0, lo_prod};
  wire [32:0]     hi_sq = {1'b0, hi_prod};
  wire [32:0]     rad_w = {{(32-2*QW){1'b0}}, rad_now};
  wire rad_raw = (ctrl_r[`SFFL_C_RLO_ON] & ~(rad_w > lo_sq)) |
                 (ctrl_r[`SFFL_C_RHI_ON] & ~(rad_w < hi_sq));

  // ------------------------------------------------------------------
  // debounce: counter per filtered flag, reset when condition drops
  // ------------------------------------------------------------------
  wire [4:0] ovf_lim = (filt_cfg > `SFFL_OVF_FILT_MAX) ? `SFFL_OVF_FILT_MAX : filt_cfg;
  wire [4:0] rad_lim = (filt_cfg > `SFFL_RAD_FILT_MAX) ? `SFFL_RAD_FILT_MAX : filt_cfg;
  wire ovf_ok = ovf_raw & (ovf_cnt_r >= ovf_lim);
  wire rad_ok = rad_raw & (rad_cnt_r >= rad_lim);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ovf_cnt_r <= 5'h00;
      rad_cnt_r <= 5'h00;
    end
    else if (update_tick)
    begin
      if (!ovf_raw)
        ovf_cnt_r <= 5'h00;
      else if (ovf_cnt_r != 5'h1F)
        ovf_cnt_r <= ovf_cnt_r + 5'h01;
      if (!rad_raw)
        rad_cnt_r <= 5'h00;
      else if (rad_cnt_r != 5'h1F)
        rad_cnt_r <= rad_cnt_r + 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // flags: set wins over clear; critical flags cleared by reset only
  // ------------------------------------------------------------------
  always @*
  begin
    flag_nxt = flag_r;
    if (clr_ev)
    begin
      if (!ovf_raw)
        flag_nxt[`SFFL_B_OVF] = 1'b0;
      if (!(selfcheck_mismatch | angle_watchdog_miss))
        flag_nxt[`SFFL_B_SELF] = 1'b0;
      if (!rad_raw)
        flag_nxt[`SFFL_B_RAD] = 1'b0;
      if (first_upd_r)
        flag_nxt[`SFFL_B_POR] = 1'b0;
      flag_nxt[`SFFL_B_ESE] = 1'b0;
      if (!undervoltage_trip)
        flag_nxt[`SFFL_B_UVD] = 1'b0;
    end
    if (update_tick & ovf_ok & ~ovf_mask)
      flag_nxt[`SFFL_B_OVF] = 1'b1;
    if (periodic & (selfcheck_mismatch | angle_watchdog_miss))
      flag_nxt[`SFFL_B_SELF] = 1'b1;
    if (update_tick & rad_ok & ~ctrl_r[`SFFL_C_RAD_MASK])
      flag_nxt[`SFFL_B_RAD] = 1'b1;
    if (eeprom_read_active & ecc_single_err & ~ctrl_r[`SFFL_C_EEPROM_ONEBIT_MASK])
      flag_nxt[`SFFL_B_ESE] = 1'b1;
    if (undervoltage_trip)
      flag_nxt[`SFFL_B_UVD] = 1'b1;
    if (periodic & shadow_parity_bad & ~ctrl_r[`SFFL_C_SHADOW_PARITY_MASK])
      flag_nxt[`SFFL_B_SPE] = 1'b1;
    if (eeprom_read_active & ecc_multi_err)
      flag_nxt[`SFFL_B_EUE] = 1'b1;
    if (periodic & osc_deviation_over & ~ctrl_r[`SFFL_C_OSC_MASK])
      flag_nxt[`SFFL_B_OSC] = 1'b1;
    if (ctrl_r[`SFFL_C_POR_MASK])
      flag_nxt[`SFFL_B_POR] = 1'b0;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_r      <= 9'h008;  // power-on flag set at startup
      period_r    <= 4'h0;
      first_upd_r <= 1'b0;
      first_out_r <= 1'b1;
      radius_r    <= {(2*QW+1){1'b0}};
    end
    else
    begin
      flag_r <= flag_nxt;
      if (update_tick)
      begin
        first_upd_r <= 1'b1;
        radius_r    <= rad_now;
        period_r    <= periodic ? 4'h0 : period_r + 4'h1;
      end
      if (report_done)
        first_out_r <= 1'b0;
    end
  end

  // first digital frame carries power-on error unless masked
  assign first_frame_por = output_is_digital & first_out_r &
                           ~ctrl_r[`SFFL_C_POR_MASK];
  assign output_error_state = flag_r[`SFFL_B_UVD] | undervoltage_trip;
  assign error_flags = flag_r;
  assign squared_radius_valid = first_upd_r;

  // ------------------------------------------------------------------
  // wishbone slave, ack one cycle after request
  // ------------------------------------------------------------------
  integer i;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r   <= `SFFL_CTRL_RST;
      limit_r  <= 32'hFFFF_0000;
      bounds_r <= 32'hFFFF_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req & wb_we_i)
      begin
        for (i = 0; i < 4; i = i + 1)
        begin
          if (wb_sel_i[i])
          begin
            case (wb_adr_i)
              `SFFL_ADR_CTRL:   ctrl_r[i*8 +: 8]   <= wb_dat_i[i*8 +: 8];
              `SFFL_ADR_LIMIT:  limit_r[i*8 +: 8]  <= wb_dat_i[i*8 +: 8];
              `SFFL_ADR_BOUNDS: bounds_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
              default:          ;
            endcase
          end
        end
      end
      if (bus_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          `SFFL_ADR_CTRL:   wb_dat_o <= ctrl_r;
          `SFFL_ADR_ERR:    wb_dat_o <= {23'h000000, flag_r};
          `SFFL_ADR_LIMIT:  wb_dat_o <= limit_r;
          `SFFL_ADR_RADIUS: wb_dat_o <= {{(31-2*QW){1'b0}}, radius_r};
          `SFFL_ADR_BOUNDS: wb_dat_o <= bounds_r;
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== design/sffl_consts.vh ====
// Purpose: constants for the sensor fault flag logic
// Assumes: 32-bit classic wishbone, word addressed by byte address
// Notes:   offsets are byte addresses, one register per word
`ifndef SFFL_CONSTS_VH
`define SFFL_CONSTS_VH

`define SFFL_ADR_CTRL      8'h00
`define SFFL_ADR_ERR       8'h04
`define SFFL_ADR_LIMIT     8'h08
`define SFFL_ADR_RADIUS    8'h0C
`define SFFL_ADR_BOUNDS    8'h10

// error register bit positions
`define SFFL_B_OVF         0
`define SFFL_B_SELF        1
`define SFFL_B_RAD         2
`define SFFL_B_POR         3
`define SFFL_B_ESE         4
`define SFFL_B_UVD         5
`define SFFL_B_SPE         6
`define SFFL_B_EUE         7
`define SFFL_B_OSC         8

// control register bit positions
`define SFFL_C_OVF_MASK    0
`define SFFL_C_LIN_MASK    1
`define SFFL_C_COR_MASK    2
`define SFFL_C_LIM_ON      3
`define SFFL_C_GAIN_ON     4
`define SFFL_C_POFF_ON     5
`define SFFL_C_OSC_MASK    6
`define SFFL_C_RAD_MASK    7
`define SFFL_C_RLO_ON      8
`define SFFL_C_RHI_ON      9
`define SFFL_C_POR_MASK    10
`define SFFL_C_EEPROM_ONEBIT_MASK    11
`define SFFL_C_SHADOW_PARITY_MASK    12
`define SFFL_C_UVD_SEL     13
`define SFFL_C_FILT_LSB    16
`define SFFL_CTRL_RST      32'h0000_0006

`define SFFL_PERIODIC_UPD  4'hA
`define SFFL_OVF_FILT_MAX  5'h10
`define SFFL_RAD_FILT_MAX  5'h08

`endif

// ==== test/sffl_props.sv ====
// Purpose: port-level checker for sffl_top
// Assumes: one clock, sync active-low reset
// Notes:   bound from the tb file
`timescale 1ns/1ps
module sffl_props (
  input wire       clk,
  input wire       rst_n,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       update_tick,
  input wire       eeprom_read_active,
  input wire       undervoltage_trip,
  input wire       output_is_digital,
  input wire       gain_clip_on,
  input wire       output_error_state,
  input wire       first_frame_por,
  input wire       squared_radius_valid,
  input wire [8:0] error_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_done; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_done; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_osc; error_flags[8] |=> error_flags[8]; endproperty
  a_osc: assert property (p_osc) else $error("osc flag dropped");
  property p_par; error_flags[6] |=> error_flags[6]; endproperty
  a_par: assert property (p_par) else $error("parity flag dropped");
  property p_eue; error_flags[7] |=> error_flags[7]; endproperty
  a_eue: assert property (p_eue) else $error("multibit flag dropped");
  property p_ecc; !eeprom_read_active && !error_flags[4] |=> !error_flags[4]; endproperty
  a_ecc: assert property (p_ecc) else $error("onebit flag outside read");
  property p_uvd; undervoltage_trip |-> output_error_state; endproperty
  a_uvd: assert property (p_uvd) else $error("trip without error output");
  property p_upd; update_tick |=> squared_radius_valid; endproperty
  a_upd: assert property (p_upd) else $error("radius not valid after update");
  property p_ctl; !$stable(gain_clip_on) |-> wb_ack_o && wb_we_i; endproperty
  a_ctl: assert property (p_ctl) else $error("clip enable moved without write");
  property p_ffp; first_frame_por |-> output_is_digital; endproperty
  a_ffp: assert property (p_ffp) else $error("first frame flag in analog mode");
endmodule

// ==== test/sffl_host.sv ====
// Purpose: host side model making angle updates and report pulses
// Assumes: driven from tb tasks
// Notes:   pulses last one cycle, updates spaced four cycles
`timescale 1ns/1ps
module sffl_host (
  input  wire clk,
  output reg  update_tick,
  output reg  report_done
);
  initial
  begin
    update_tick = 1'b0;
    report_done = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk) update_tick <= 1'b1;
      @(posedge clk) update_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // extra edges so the clear has landed on return
  task automatic report;
    @(posedge clk) report_done <= 1'b1;
    @(posedge clk) report_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for sffl_top
// Assumes: host model makes updates and reports
// Notes:   correction sources and pre-gain angle driven by t_cor
`timescale 1ns/1ps
`include "sffl_consts.vh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [10:0] src = 11'h400;
  logic [15:0] sa = 16'h0;
  logic [15:0] sb = 16'h0;
  logic [3:0]  cor = 4'h0;
  logic [15:0] ang = 16'h0150;
  logic [31:0] rdat;
  logic [8:0]  err;
  logic [2:0]  cfg;
  logic        ack, tick, rep, uerr, ffp;
  int          fails = 0;
  int          total_checks = 0;
  always #2 clk = ~clk;
  sffl_host host (.clk(clk), .update_tick(tick), .report_done(rep));
  sffl_top dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .update_tick(tick), .linearizer_overflow(src[0]), .frontend_overflow(src[1]),
    .factory_trim_overflow(cor[0]), .customer_trim_overflow(cor[1]), .pre_gain_angle(ang),
    .gain_overflow(cor[2]), .post_offset_overflow(cor[3]), .osc_deviation_over(src[2]),
    .selfcheck_mismatch(src[3]), .angle_watchdog_miss(src[4]), .first_axis_sample(sa),
    .second_axis_sample(sb), .eeprom_read_active(src[5]), .ecc_single_err(src[6]),
    .ecc_multi_err(src[7]), .shadow_parity_bad(src[8]), .undervoltage_trip(src[9]),
    .report_done(rep), .output_is_digital(src[10]), .gain_clip_on(cfg[0]),
    .post_offset_clip_on(cfg[1]), .uvd_threshold_high(cfg[2]), .output_error_state(uerr),
    .first_frame_por(ffp), .squared_radius_valid(), .error_flags(err));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 100)
      fails++;
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic t_por;
    chk("flags", err, 32'h8);
    chk("first frame", ffp, 32'h1);
    rd(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    rd(`SFFL_ADR_ERR, 32'h8);
    host.tick(1);
    rd(`SFFL_ADR_ERR, 32'h8);
    rd(`SFFL_ADR_ERR, 32'h0);
    $display("test power-on done");
  endtask
  task automatic t_ovf;
    src[0] <= 1'b1;
    host.tick(2);
    chk("lin masked", err, 32'h0);
    src[1:0] <= 2'b10;
    host.tick(1);
    rd(`SFFL_ADR_ERR, 32'h1);
    rd(`SFFL_ADR_ERR, 32'h1);
    src[1] <= 1'b0;
    host.report;
    chk("ovf cleared", err, 32'h0);
    wr(`SFFL_ADR_CTRL, 32'h7);
    src[1] <= 1'b1;
    host.tick(2);
    chk("ovf masked", err, 32'h0);
    src[1] <= 1'b0;
    host.tick(1);
    wr(`SFFL_ADR_CTRL, 32'h0003_0006);
    src[1] <= 1'b1;
    host.tick(2);
    chk("debounce early", err, 32'h0);
    host.tick(2);
    chk("debounce late", err, 32'h1);
    src[1] <= 1'b0;
    host.report;
    wr(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    $display("test overflow done");
  endtask
  task automatic t_rad;
    {sa, sb} <= {16'h0180, 16'h0200};
    wr(`SFFL_ADR_BOUNDS, 32'h0006_0005);
    wr(`SFFL_ADR_CTRL, 32'h0106);
    host.tick(1);
    rd(`SFFL_ADR_RADIUS, 32'h19);
    rd(`SFFL_ADR_ERR, 32'h4);
    wr(`SFFL_ADR_BOUNDS, 32'h0005_0004);
    host.tick(1);
    host.report;
    chk("radius inside", err, 32'h0);
    wr(`SFFL_ADR_CTRL, 32'h0386);
    wr(`SFFL_ADR_BOUNDS, 32'h0005_0000);
    host.tick(1);
    chk("radius masked", err, 32'h0);
    wr(`SFFL_ADR_CTRL, 32'h0206);
    host.tick(1);
    rd(`SFFL_ADR_ERR, 32'h4);
    wr(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    host.tick(1);
    host.report;
    $display("test radius done");
  endtask
  task automatic t_cfg;
    wr(`SFFL_ADR_CTRL, 32'h2036);
    chk("cfg bits", cfg, 32'h7);
    wr(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    chk("cfg bits", cfg, 32'h0);
    rd(8'h14, 32'h0);
    wr(`SFFL_ADR_ERR, 32'hFFFF_FFFF);
    rd(`SFFL_ADR_ERR, 32'h0);
    $display("test config done");
  endtask
  task automatic t_cor;
    wr(`SFFL_ADR_LIMIT, 32'h0200_0100);
    wr(`SFFL_ADR_CTRL, 32'h0000_003A);
    for (int k = 0; k < 5; k++)
    begin
      if (k < 4)
        cor[k] <= 1'b1;
      else
        ang <= 16'h0050;
      host.tick(1);
      rd(`SFFL_ADR_ERR, 32'h1);
      cor <= 4'h0;
      ang <= 16'h0150;
      host.report;
      chk("cor cleared", err, 32'h0);
    end
    wr(`SFFL_ADR_CTRL, 32'h0000_002A);
    cor[2] <= 1'b1;
    host.tick(1);
    chk("gain clip off", err, 32'h0);
    cor[2] <= 1'b0;
    wr(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    cor[0] <= 1'b1;
    host.tick(1);
    chk("cor masked", err, 32'h0);
    cor[0] <= 1'b0;
    chk("first frame gone", ffp, 32'h0);
    sel <= 4'h2;
    wr(`SFFL_ADR_CTRL, 32'hFFFF_FF00);
    sel <= 4'hF;
    rd(`SFFL_ADR_CTRL, 32'h0000_FF06);
    wr(`SFFL_ADR_CTRL, `SFFL_CTRL_RST);
    host.tick(1);
    $display("test correction done");
  endtask
  task automatic t_crit;
    src[8:2] <= 7'h47;
    host.tick(10);
    src[8:2] <= 7'h00;
    rd(`SFFL_ADR_ERR, 32'h142);
    rd(`SFFL_ADR_ERR, 32'h140);
    src[7:5] <= 3'h7;
    repeat (3) @(posedge clk);
    src[7:5] <= 3'h0;
    rd(`SFFL_ADR_ERR, 32'h1D0);
    rd(`SFFL_ADR_ERR, 32'h1C0);
    src[9] <= 1'b1;
    repeat (2) @(posedge clk);
    chk("uvd out", uerr, 32'h1);
    src[9] <= 1'b0;
    repeat (2) @(posedge clk);
    chk("uvd held", uerr, 32'h1);
    rd(`SFFL_ADR_ERR, 32'h1E0);
    @(posedge clk);
    chk("uvd released", uerr, 32'h0);
    $display("test critical done");
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_por;
    t_ovf;
    t_rad;
    t_cfg;
    t_cor;
    t_crit;
    wrap_up;
  end
  // about sixty times the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
bind sffl_top sffl_props u_props (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .update_tick,
  .eeprom_read_active, .undervoltage_trip, .output_is_digital, .gain_clip_on, .output_error_state,
  .first_frame_por, .squared_radius_valid, .error_flags);
